//--- src_pkg.sv
// constants and types for the speed reference conditioner
package src_pkg;
   localparam int          SRC_REF_W       = 16;   // signed reference code, 1 lsb = 1 mV
   localparam int          SRC_SPD_W       = 24;   // signed speed, 1 lsb = 1/256 rpm
   localparam int          SRC_FRAC        = 8;
   localparam int          SRC_MV_PER_V    = 1000;
   localparam logic [11:0] SRC_GAIN_MAX    = 12'hbb8;   // 3000 rpm/V
   localparam logic [11:0] SRC_GAIN_RST    = 12'h096;   // 150 rpm/V
   localparam logic [13:0] SRC_TIME_MAX    = 14'h2710;  // 10000 ms
   localparam logic [13:0] SRC_TIME_RST    = 14'h0000;
   localparam logic [3:0]  SRC_MODE_ANALOG = 4'h0;
   localparam logic [1:0]  SRC_CURVE_RAMP  = 2'h0;
   localparam logic [1:0]  SRC_CURVE_S     = 2'h1;
   localparam logic [1:0]  SRC_CURVE_F1    = 2'h2;
   localparam logic [1:0]  SRC_CURVE_F2    = 2'h3;
   localparam int          SRC_OFS_LIM     = 1024;
   localparam int          SRC_RAMP_RPM    = 1000;
   localparam int          SRC_TICK_US     = 1000;  // one control tick per ms
   localparam int          SRC_FILT_SHIFT  = 4;
   typedef enum logic [1:0] {SRC_IDLE, SRC_MEASURE} src_ofs_state_t;
endpackage

//--- src_conditioner.sv
// speed reference conditioner: gain, offset and soft-start shaping
module src_conditioner
   import src_pkg::*;
(
   input  wire logic                          ref_clk,
   input  wire logic                          reset_n,
   input  wire logic                          clk_en,
   input  wire logic                          tick,
   input  wire logic signed [src_pkg::SRC_REF_W-1:0] vref_code,
   input  wire logic [3:0]                    control_mode_select,
   input  wire logic [11:0]                   speed_input_gain,
   input  wire logic [1:0]                    speed_curve_form,
   input  wire logic [13:0]                   soft_accel_time,
   input  wire logic [13:0]                   soft_decel_time,
   input  wire logic                          preset_sel,
   input  wire logic signed [src_pkg::SRC_SPD_W-1:0] preset_speed,
   input  wire logic                          auto_offset_function,
   input  wire logic                          manual_offset_function,
   input  wire logic signed [11:0]            manual_offset_value,
   input  wire logic                          factory_restore_function,
   output logic                               analog_mode,
   output logic signed [11:0]                 offset_stored,
   output logic signed [src_pkg::SRC_SPD_W-1:0] speed_target,
   output logic signed [src_pkg::SRC_SPD_W-1:0] speed_cmd
);
   import src_pkg::*;

   localparam logic signed [11:0] OFS_HI = 12'sh400;
   localparam logic signed [11:0] OFS_LO = -12'sh400;
   localparam int MAX_RPM_SCALED = SRC_RAMP_RPM * (1 << SRC_FRAC);
   // zero time: the largest positive step, so the ramp lands in one tick when target and output differ by no more
   localparam logic signed [SRC_SPD_W-1:0] STEP_JUMP = {1'b0, {(SRC_SPD_W-1){1'b1}}};

   // vref is a pin: two-stage synchroniser before use
   logic signed [SRC_REF_W-1:0] vref_s1;
   logic signed [SRC_REF_W-1:0] vref;
   logic                        sync_pre;
   logic                        sync_valid;

   // restart-latched settings
   logic [3:0]  mode_q;
   logic [1:0]  curve_q;
   logic        started;

   logic signed [11:0]          ofs;
   logic signed [SRC_SPD_W-1:0] tgt;
   logic signed [SRC_SPD_W-1:0] out;
   logic signed [SRC_SPD_W-1:0] stage1;

   logic signed [11:0]          next_ofs;
   logic signed [SRC_SPD_W-1:0] next_tgt;
   logic signed [SRC_SPD_W-1:0] next_out;
   logic signed [SRC_SPD_W-1:0] next_stage1;

   logic [11:0]                 gain_c;
   logic [13:0]                 acc_c;
   logic [13:0]                 dec_c;
   logic signed [SRC_REF_W:0]   vcorr;
   logic signed [40:0]          prod;
   logic signed [SRC_SPD_W-1:0] step;
   logic signed [SRC_SPD_W:0]   diff;
   logic                        accel;

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         vref_s1    <= '0;
         vref       <= '0;
         sync_pre   <= 1'b0;
         sync_valid <= 1'b0;
      end
      else if (clk_en)
      begin
         vref_s1    <= vref_code;
         vref       <= vref_s1;
         sync_pre   <= 1'b1;
         sync_valid <= sync_pre;
      end
   end

   // settings caught once after reset release, so later changes need a restart
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         mode_q  <= SRC_MODE_ANALOG;
         curve_q <= SRC_CURVE_RAMP;
         started <= 1'b0;
      end
      else if (clk_en && !started)
      begin
         mode_q  <= control_mode_select;
         curve_q <= speed_curve_form;
         started <= 1'b1;
      end
   end

   assign analog_mode = started && (mode_q == SRC_MODE_ANALOG);

   always_comb
   begin
      gain_c = (speed_input_gain > SRC_GAIN_MAX) ? SRC_GAIN_MAX : speed_input_gain;
      acc_c  = (soft_accel_time > SRC_TIME_MAX) ? SRC_TIME_MAX : soft_accel_time;
      dec_c  = (soft_decel_time > SRC_TIME_MAX) ? SRC_TIME_MAX : soft_decel_time;
      vcorr  = (SRC_REF_W+1)'(vref) - (SRC_REF_W+1)'(ofs);
      // signed product keeps sign, so polarity maps to direction
      prod   = 41'(vcorr) * $signed({1'b0, gain_c}) * 41'sd256
               / 41'(SRC_MV_PER_V);
   end

   // offset storage: never touched by factory restore
   always_comb
   begin
      next_ofs = ofs;
      if (auto_offset_function && sync_valid)
      begin
         if (vref > SRC_REF_W'(OFS_HI))
            next_ofs = OFS_HI;
         else if (vref < SRC_REF_W'(OFS_LO))
            next_ofs = OFS_LO;
         else
            next_ofs = 12'(vref);
      end
      else if (manual_offset_function)
      begin
         if (manual_offset_value > OFS_HI)
            next_ofs = OFS_HI;
         else if (manual_offset_value < OFS_LO)
            next_ofs = OFS_LO;
         else
            next_ofs = manual_offset_value;
      end
   end

   // target: analog path or presets, both go through soft start
   always_comb
   begin
      next_tgt = tgt;
      if (preset_sel)
         next_tgt = preset_speed;
      else if (analog_mode)
         next_tgt = SRC_SPD_W'(prod);
      else
         next_tgt = '0;
   end

   // ramp step per tick = 1000 rpm / (time in ticks); zero time means a direct jump
   always_comb
   begin
      diff  = (SRC_SPD_W+1)'(tgt) - (SRC_SPD_W+1)'(out);
      accel = (tgt >= 0) ? (diff > 0) : (diff < 0);
      if (accel)
         step = (acc_c == '0) ? STEP_JUMP
                              : SRC_SPD_W'(MAX_RPM_SCALED / int'(acc_c));
      else
         step = (dec_c == '0) ? STEP_JUMP
                              : SRC_SPD_W'(MAX_RPM_SCALED / int'(dec_c));
      if (step == '0)
         step = SRC_SPD_W'(1);
      next_out    = out;
      next_stage1 = stage1;
      if (tick)
      begin
         case (curve_q)
            SRC_CURVE_RAMP, SRC_CURVE_S:
            begin
               // s-curve shaping is not modelled: it falls back on the ramp
               if (diff > step)
                  next_out = out + step;
               else if (diff < -step)
                  next_out = out - step;
               else
                  next_out = tgt;
               next_stage1 = next_out;
            end
            SRC_CURVE_F1:
            begin
               next_out    = out + ((tgt - out) >>> SRC_FILT_SHIFT);
               next_stage1 = next_out;
            end
            SRC_CURVE_F2:
            begin
               next_stage1 = stage1 + ((tgt - stage1) >>> SRC_FILT_SHIFT);
               next_out    = out + ((stage1 - out) >>> SRC_FILT_SHIFT);
            end
            default:
            begin
               next_out    = tgt;
               next_stage1 = tgt;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         ofs    <= '0;
         tgt    <= '0;
         out    <= '0;
         stage1 <= '0;
      end
      else if (clk_en)
      begin
         ofs    <= next_ofs;
         tgt    <= next_tgt;
         out    <= next_out;
         stage1 <= next_stage1;
      end
   end

   assign offset_stored = ofs;
   assign speed_target  = tgt;
   assign speed_cmd     = out;

   ofs_range_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (ofs <= OFS_HI) && (ofs >= OFS_LO))
      else $error("offset out of range");

   ofs_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (clk_en && !auto_offset_function && !manual_offset_function) |=> $stable(ofs))
      else $error("offset changed without request");

   restore_keep_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (clk_en && factory_restore_function && !auto_offset_function
       && !manual_offset_function) |=> $stable(ofs))
      else $error("factory restore touched the offset");

   manual_take_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (clk_en && manual_offset_function && !auto_offset_function
       && (manual_offset_value <= OFS_HI) && (manual_offset_value >= OFS_LO))
      |=> (ofs == $past(manual_offset_value)))
      else $error("manual offset not applied");

   manual_clamp_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (clk_en && manual_offset_function && !auto_offset_function
       && (manual_offset_value > OFS_HI)) |=> (ofs == OFS_HI))
      else $error("manual offset not limited");

   auto_take_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (clk_en && auto_offset_function && sync_valid
       && (vref <= SRC_REF_W'(OFS_HI)) && (vref >= SRC_REF_W'(OFS_LO)))
      |=> (SRC_REF_W'(ofs) == $past(vref)))
      else $error("measured offset not stored");

   mode_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      started |=> $stable(mode_q) && $stable(curve_q))
      else $error("mode changed without restart");

   mode_latch_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(started) |-> (mode_q == $past(control_mode_select))
      && (curve_q == $past(speed_curve_form)))
      else $error("settings not caught at restart");

   ramp_step_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (clk_en && tick && curve_q == SRC_CURVE_RAMP && diff > step) |=>
      (out == $past(out) + $past(step)))
      else $error("ramp step wrong");

   ramp_down_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (clk_en && tick && curve_q == SRC_CURVE_RAMP && diff < -step) |=>
      (out == $past(out) - $past(step)))
      else $error("ramp down step wrong");

   ramp_land_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (clk_en && tick && curve_q == SRC_CURVE_RAMP && diff <= step && diff >= -step) |=>
      (out == $past(tgt)))
      else $error("ramp missed target");

   ramp_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (clk_en && !tick) |=> $stable(out))
      else $error("output moved without tick");

   freeze_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !clk_en |=> $stable(out) && $stable(tgt) && $stable(ofs))
      else $error("state moved while disabled");

   filt_one_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (clk_en && tick && curve_q == SRC_CURVE_F1) |=>
      (out == $past(out) + (($past(tgt) - $past(out)) >>> SRC_FILT_SHIFT)))
      else $error("first order filter step wrong");

   filt_two_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (clk_en && tick && curve_q == SRC_CURVE_F2) |=>
      (out == $past(out) + (($past(stage1) - $past(out)) >>> SRC_FILT_SHIFT)))
      else $error("second order filter step wrong");

   preset_path_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (clk_en && preset_sel) |=> (tgt == $past(preset_speed)))
      else $error("preset not taken");

   dir_sign_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (clk_en && !preset_sel && analog_mode && vcorr > 0 && gain_c >= 12'h004) |=>
      (tgt > 0))
      else $error("forward direction wrong");

   dir_rev_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (clk_en && !preset_sel && analog_mode && vcorr < 0 && gain_c >= 12'h004) |=>
      (tgt < 0))
      else $error("reverse direction wrong");

   sync_delay_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (clk_en && $past(clk_en) && $past(reset_n)) |=> (vref == $past(vref_code, 2)))
      else $error("reference synchroniser delay wrong");
endmodule

//--- src_host.sv
// host controller model driving the analog speed reference
module src_host
   import src_pkg::*;
#(
   parameter int DRIFT_MV = 5   // small deviation seen at the pins with a 0 V command
)
(
   input  wire logic                            ref_clk,
   input  wire logic signed [15:0]              level_mv,
   output logic signed [src_pkg::SRC_REF_W-1:0] vref_code
);
   timeunit 1ns;
   timeprecision 1ps;
   logic signed [src_pkg::SRC_REF_W-1:0] level_q = '0;
   // no rail saturation: the bench keeps levels inside +-10 V
   // level caught on the rising edge, pin moved on the falling one: no race with the bench
   always @(posedge ref_clk)
      level_q <= level_mv + 16'(DRIFT_MV);
   always @(negedge ref_clk)
      vref_code <= level_q;
endmodule

//--- tb_top.sv
// self-checking testbench for the speed reference conditioner
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import src_pkg::*;
   logic               ref_clk  = 1'b0;
   logic               reset_n  = 1'b0;
   logic               tick     = 1'b0;
   logic [3:0]         mode     = 4'h0;
   logic               en       = 1'b1;
   logic [1:0]         curve    = 2'h0;
   logic [11:0]        gain     = 12'h096;
   logic [13:0]        acc      = 14'h0000;
   logic [13:0]        dec      = 14'h0000;
   logic               psel     = 1'b0;
   logic signed [23:0] pspd     = 24'h000000;
   logic               aofs     = 1'b0;
   logic               mofs     = 1'b0;
   logic               frst     = 1'b0;
   logic signed [11:0] mval     = 12'h000;
   logic signed [15:0] level    = 16'h0000;
   logic signed [15:0] vref;
   logic               amode;
   logic signed [11:0] ofs;
   logic signed [23:0] tgt;
   logic signed [23:0] cmd;
   int                 n_fail   = 0;
   int                 compares = 0;
   always #12.5 ref_clk = ~ref_clk;
   src_host host_u (.ref_clk(ref_clk), .level_mv(level), .vref_code(vref));
   src_conditioner dut_u (
      .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(en), .tick(tick), .vref_code(vref),
      .control_mode_select(mode), .speed_input_gain(gain), .speed_curve_form(curve),
      .soft_accel_time(acc), .soft_decel_time(dec), .preset_sel(psel), .preset_speed(pspd),
      .auto_offset_function(aofs), .manual_offset_function(mofs), .manual_offset_value(mval),
      .factory_restore_function(frst), .analog_mode(amode), .offset_stored(ofs),
      .speed_target(tgt), .speed_cmd(cmd));
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %0d seen %0d", what, $signed(exp), $signed(got));
      end
   endtask
   // one tick, then an idle cycle so a following call raises tick on a fresh edge
   task automatic tick_chk(input logic [23:0] exp);
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
      cyc(1);
      chk("speed_cmd", exp, cmd);
   endtask
   task automatic manual(input logic [11:0] v, input logic [23:0] exp);
      mval = v;
      mofs = 1'b1;
      cyc(1);
      mofs = 1'b0;
      cyc(1);
      chk("offset_stored", exp, 24'(ofs));
   endtask
   // restart with a new curve form; settings are caught on the first edge after release
   task automatic restart(input logic [1:0] c);
      reset_n = 1'b0;
      curve   = c;
      cyc(3);
      reset_n = 1'b1;
      cyc(2);
   endtask
   // new level, then wait out the two sync flops and the target register
   task automatic set_ref(input logic [15:0] mv, input logic [23:0] exp);
      level = mv;
      cyc(4);
      chk("speed_target", exp, tgt);
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      cyc(5000);
      n_fail++;
      finish_test();
   end
   initial
   begin
      cyc(10);
      reset_n = 1'b1;
      cyc(3);
      chk("analog_mode", 24'h1, 24'(amode));
      mode = 4'h1;
      cyc(3);
      chk("analog_mode", 24'h1, 24'(amode));
      manual(12'h7ff, 24'h000400);
      manual(12'h800, 24'hfffc00);
      manual(12'h064, 24'h000064);
      level = 16'h0000;
      cyc(4);
      aofs = 1'b1;
      cyc(1);
      aofs = 1'b0;
      chk("offset_stored", 24'h5, 24'(ofs));
      frst = 1'b1;
      cyc(1);
      frst = 1'b0;
      cyc(1);
      chk("offset_stored", 24'h5, 24'(ofs));
      set_ref(16'h03e8, 24'h009600);
      set_ref(16'hd8f0, 24'hfa2400);
      gain = 12'hfff;
      set_ref(16'h03e8, 24'h0bb800);
      gain = 12'h3e8;
      acc = 14'h0004;
      set_ref(16'h03e8, 24'h03e800);
      for (int i = 1; i <= 4; i++)
         tick_chk(24'(i * 64000));
      tick_chk(24'h03e800);
      dec = 14'h0002;
      set_ref(16'h0000, 24'h000000);
      tick_chk(24'h01f400);
      tick_chk(24'h000000);
      acc = 14'h0000;
      set_ref(16'h03e8, 24'h03e800);
      tick_chk(24'h03e800);
      dec = 14'h0004;
      pspd = 24'h006400;
      psel = 1'b1;
      cyc(1);
      chk("speed_target", 24'h006400, tgt);
      for (int i = 1; i <= 3; i++)
         tick_chk(24'(256000 - i * 64000));
      tick_chk(24'h006400);
      en   = 1'b0;
      pspd = 24'h00c800;
      tick = 1'b1;
      cyc(2);
      chk("speed_target", 24'h006400, tgt);
      chk("speed_cmd", 24'h006400, cmd);
      tick = 1'b0;
      pspd = 24'h006400;
      en   = 1'b1;
      cyc(1);
      restart(2'h2);
      chk("analog_mode", 24'h0, 24'(amode));
      chk("speed_target", 24'h006400, tgt);
      tick_chk(24'h000640);
      tick_chk(24'h000c1c);
      curve = 2'h0;
      tick_chk(24'h00119a);
      restart(2'h3);
      tick_chk(24'h000000);
      tick_chk(24'h000064);
      finish_test();
   end
endmodule
